/* File: core/link_unit.v */
// link interface unit: apb registers, word window, four link channels
// assumes an apb master on sys_clk and remote terminals on the wires
//
// How it works
// R1 - each channel swaps a 16-bit word over one signal wire plus return
// R2 - fifteen-plus-error mode passes inputs 0..14, bit 15 is error flag
// R3 - sixteen-input mode presents all sixteen inputs, bit 15 is input 15
// R4 - inputs 0..14 land on word bits 0..14 in both modes
// R5 - point 15 indicator follows input 15 only in sixteen-input mode
// R6 - error indicator lights on error, clears at next good frame
// R7 - the remote terminal holds its last good word during an error
// R8 - remote terminal sends zeros first after its own power-up
// R9 - output channels do no error detection of their own
// R10 - one update takes about 19.2 ms and at most 31 ms
// R11 - an input held 16 ms or more is sure to be seen
// R12 - software holds each output bit longer than 16 ms
// R13 - the unit serves two or four channels, 32 or 64 points
// R14 - the word block starts at the base chosen by the unit number
// R15 - one word per channel, two or four consecutive words
// R16 - point indicators show live received or sent bits
// R17 - error when no valid frame within the longest delay, cleared by one
// R18 - in error-flag mode bit 15 reads one exactly while in error
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "link_regs.vh"
module link_unit #(
  parameter BIT_CYC   = `BIT_CYC,
  parameter FRAME_CYC = `FRAME_CYC,
  parameter ERR_CYC   = `ERR_CYC
) (
  input  wire        sys_clk,
  input  wire        srst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         irq,
  input  wire [2:0]  unit_sel,
  input  wire [3:0]  serial_line_terminal_i,
  output wire [3:0]  serial_line_terminal_o,
  output wire [3:0]  serial_line_terminal_oe,
  output reg  [63:0] point_led,
  output reg  [3:0]  err_led,
  output reg         mode_led
);
  reg  [7:0]  ctrl_reg;
  reg  [7:0]  status_reg;
  reg  [7:0]  status_next;
  reg  [7:0]  mask_reg;
  reg  [63:0] out_reg;
  reg  [2:0]  strap_sync_reg;
  reg  [2:0]  strap_s2_reg;
  reg  [2:0]  strap_s3_reg;
  reg  [1:0]  strap_fill_reg;
  reg  [2:0]  unit_reg;
  reg         unit_done_reg;
  reg  [3:0]  err_d_reg;
  wire [63:0] rx_words;
  wire [3:0]  rx_errs;
  wire [3:0]  frames;
  wire [63:0] pres_words;
  wire [63:0] led_next;
  wire [3:0]  ch_en;
  wire        mode15 = ctrl_reg[`CTRL_MODE_BIT];
  wire        four   = ctrl_reg[`CTRL_FOUR_BIT];
  wire [3:0]  dir    = ctrl_reg[`CTRL_DIR_LSB +: 4];

  // base of the word block follows the unit number, not the slot
  wire [7:0]  win_base = `WIN_OFS + {unit_reg, 4'h0} ;          // [R14]
  wire [7:0]  win_off  = paddr - win_base;
  wire        in_win   = (paddr >= win_base) &&
                         (win_off < (four ? 8'h10 : 8'h08));   // [R15]
  wire [1:0]  win_ch   = win_off[3:2];

  wire        acc      = psel & penable & pready;
  wire        wr       = acc & pwrite;

  assign ch_en = four ? 4'hf : 4'h3;                            // [R13]

  // the unit number is a static strap, caught once after reset; the fill
  // count keeps the reset contents of the chain from being taken
  always @(posedge sys_clk) begin
    if (srst) begin
      strap_sync_reg <= 3'h0;
      strap_s2_reg   <= 3'h0;
      strap_s3_reg   <= 3'h0;
      strap_fill_reg <= 2'h0;
      unit_reg       <= 3'h0;
      unit_done_reg  <= 1'b0;
    end else begin
      strap_sync_reg <= unit_sel;
      strap_s2_reg   <= strap_sync_reg;
      strap_s3_reg   <= strap_s2_reg;
      if (strap_fill_reg != 2'h3)
        strap_fill_reg <= strap_fill_reg + 2'h1;
      else if (!unit_done_reg && strap_s2_reg == strap_s3_reg) begin
        unit_reg      <= strap_s3_reg;                          // [R14]
        unit_done_reg <= 1'b1;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < `NUM_CH; g = g + 1) begin : chan
      link_chan #(
        .BIT_CYC   (BIT_CYC),
        .FRAME_CYC (FRAME_CYC),
        .ERR_CYC   (ERR_CYC)
      ) u_chan (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .enable   (ch_en[g]),
        .is_out   (dir[g]),
        .tx_word  (out_reg[16*g +: 16]),
        .line_i   (serial_line_terminal_i[g]),
        .line_o   (serial_line_terminal_o[g]),
        .line_oe  (serial_line_terminal_oe[g]),
        .rx_word  (rx_words[16*g +: 16]),
        .rx_err   (rx_errs[g]),
        .frame_ok (frames[g])
      );
      // bits 0..14 pass straight in either mode
      assign pres_words[16*g +: 15] = rx_words[16*g +: 15];     // [R4]
      assign pres_words[16*g + 15]  = mode15 ? rx_errs[g] :     // [R2] [R18]
                                      rx_words[16*g + 15];      // [R3]
      assign led_next[16*g +: 15] = dir[g] ? out_reg[16*g +: 15] :
                                    rx_words[16*g +: 15];       // [R16]
      assign led_next[16*g + 15] = dir[g] ? out_reg[16*g + 15] :
                                   (mode15 ? 1'b0 :             // [R5]
                                    rx_words[16*g + 15]);
    end
  endgenerate

  // indicators are registered so every pin comes from a flop
  always @(posedge sys_clk) begin
    if (srst) begin
      point_led <= 64'h0000000000000000;
      err_led   <= 4'h0;
      mode_led  <= 1'b0;
      err_d_reg <= 4'h0;
    end else begin
      point_led <= led_next;                                    // [R16]
      err_led   <= rx_errs & ~dir & ch_en;                      // [R6] [R9]
      mode_led  <= mode15;
      err_d_reg <= rx_errs;
    end
  end

  // sticky events; a new event wins over a clear in the same cycle
  always @* begin
    status_next = status_reg;
    if (wr && paddr == `STATUS_OFS)
      status_next = status_reg & ~pwdata[7:0];
    status_next[`EVT_ERR_LSB +: 4] = status_next[`EVT_ERR_LSB +: 4] |
                                     (rx_errs & ~err_d_reg);   // [R6]
    status_next[`EVT_FRM_LSB +: 4] = status_next[`EVT_FRM_LSB +: 4] |
                                     frames;
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      status_reg <= 8'h00;
      irq        <= 1'b0;
    end else begin
      status_reg <= status_next;
      irq        <= |(status_reg & mask_reg);
    end
  end

  // software writes; output words should stay put past 16 ms
  always @(posedge sys_clk) begin
    if (srst) begin
      ctrl_reg <= `CTRL_RST;
      mask_reg <= `MASK_RST;
      out_reg  <= 64'h0000000000000000;
    end else if (wr) begin
      if (paddr == `CTRL_OFS)
        ctrl_reg <= pwdata[7:0];
      else if (paddr == `MASK_OFS)
        mask_reg <= pwdata[7:0];
      else if (in_win && dir[win_ch])
        out_reg[16*win_ch +: 16] <= pwdata[15:0];               // [R12]
    end
  end

  // one wait state: pready rises in the second access cycle
  always @(posedge sys_clk) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (psel && penable && !pready) begin
        if (paddr == `CTRL_OFS)
          prdata <= {24'h000000, ctrl_reg};
        else if (paddr == `STATUS_OFS)
          prdata <= {24'h000000, status_reg};
        else if (paddr == `MASK_OFS)
          prdata <= {24'h000000, mask_reg};
        else if (paddr == `UNIT_OFS)
          prdata <= {16'h0000, win_base, 5'h00, unit_reg};
        else if (in_win)
          prdata <= {16'h0000, dir[win_ch] ? out_reg[16*win_ch +: 16] :
                                             pres_words[16*win_ch +: 16]};
        else
          pslverr <= 1'b1;
      end
    end
  end
endmodule // link_unit

/* File: include/link_regs.vh */
// register map, field positions and timing counts of the link unit
// assumes a 10 MHz system clock and 32-bit apb data
`ifndef LINK_REGS_VH
`define LINK_REGS_VH

`define CLK_MHZ        10
`define NUM_CH         4
`define WORD_W         16

// byte offsets
`define CTRL_OFS       8'h00
`define STATUS_OFS     8'h04
`define MASK_OFS       8'h08
`define UNIT_OFS       8'h0c
`define WIN_OFS        8'h40
`define UNIT_STRIDE    8'h10

// ctrl fields
`define CTRL_MODE_BIT  0
`define CTRL_FOUR_BIT  1
`define CTRL_DIR_LSB   4
`define CTRL_RST       8'h00

// status and mask fields: [3:0] error raised, [7:4] frame received
`define EVT_ERR_LSB    0
`define EVT_FRM_LSB    4
`define MASK_RST       8'h00

// timing in microseconds, then cycles
`define BIT_TIME_US    1000
`define TYP_DELAY_US   19200
`define MAX_DELAY_US   31000
`define MIN_INPUT_US   16000
`define BIT_CYC        (`BIT_TIME_US * `CLK_MHZ)
`define FRAME_CYC      (`TYP_DELAY_US * `CLK_MHZ)
`define ERR_CYC        (`MAX_DELAY_US * `CLK_MHZ)
`define FRAME_BITS     19

`endif

/* File: core/link_chan.v */
// one link channel: frame sender or receiver on a single signal wire
// assumes line_i is an asynchronous pin; timing counts come from the top
`timescale 1ns/1ps
module link_chan #(
  parameter BIT_CYC   = 10000,
  parameter FRAME_CYC = 192000,
  parameter ERR_CYC   = 310000
) (
  input  wire        sys_clk,
  input  wire        srst,
  input  wire        enable,
  input  wire        is_out,
  input  wire [15:0] tx_word,
  input  wire        line_i,
  output reg         line_o,
  output reg         line_oe,
  output reg  [15:0] rx_word,
  output reg         rx_err,
  output reg         frame_ok
);
  localparam ST_IDLE = 2'd0;
  localparam ST_START = 2'd1;
  localparam ST_DATA = 2'd2;
  localparam ST_STOP = 2'd3;

  reg [2:0]  sync_reg;
  reg        lvl_reg;
  reg [1:0]  state_reg;
  reg [19:0] cyc_reg;
  reg [4:0]  bit_reg;
  reg [16:0] shift_reg;
  reg [19:0] tmo_reg;
  reg [19:0] tx_cyc_reg;
  reg [18:0] tx_sh_reg;
  wire       rx_on = enable & ~is_out;

  // a change counts only once the second and third stage agree
  always @(posedge sys_clk) begin
    if (srst) begin
      sync_reg <= 3'h7;
      lvl_reg  <= 1'b1;
    end else begin
      sync_reg <= {sync_reg[1:0], line_i};
      if (sync_reg[1] == sync_reg[2])
        lvl_reg <= sync_reg[2];
    end
  end

  // frame: start low, 16 data lsb first, even parity, stop high
  always @(posedge sys_clk) begin
    frame_ok <= 1'b0;
    if (srst || !rx_on) begin
      state_reg <= ST_IDLE;
      cyc_reg   <= 20'h00000;
      bit_reg   <= 5'h00;
      shift_reg <= 17'h00000;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          cyc_reg <= 20'h00000;
          if (!lvl_reg)
            state_reg <= ST_START;
        end
        ST_START: begin
          cyc_reg <= cyc_reg + 20'h00001;
          if (cyc_reg == BIT_CYC / 2) begin
            cyc_reg   <= 20'h00000;
            bit_reg   <= 5'h00;
            state_reg <= lvl_reg ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA: begin
          cyc_reg <= cyc_reg + 20'h00001;
          if (cyc_reg == BIT_CYC - 1) begin
            cyc_reg   <= 20'h00000;
            shift_reg <= {lvl_reg, shift_reg[16:1]};
            bit_reg   <= bit_reg + 5'h01;
            if (bit_reg == 5'h10)
              state_reg <= ST_STOP;
          end
        end
        ST_STOP: begin
          cyc_reg <= cyc_reg + 20'h00001;
          if (cyc_reg == BIT_CYC - 1) begin
            state_reg <= ST_IDLE;
            if (lvl_reg && (^shift_reg) == 1'b0)  // [R17]
              frame_ok <= 1'b1;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // last good word is kept through an error
  always @(posedge sys_clk) begin
    if (srst) begin
      rx_word <= 16'h0000;
      rx_err  <= 1'b0;
      tmo_reg <= 20'h00000;
    end else if (!rx_on) begin
      rx_err  <= 1'b0;                            // [R9]
      tmo_reg <= 20'h00000;
    end else if (frame_ok) begin
      rx_word <= shift_reg[15:0];                 // [R1] [R11]
      rx_err  <= 1'b0;                            // [R6] [R17]
      tmo_reg <= 20'h00000;
    end else if (tmo_reg == ERR_CYC - 1) begin
      rx_err  <= 1'b1;                            // [R17] [R10]
    end else begin
      tmo_reg <= tmo_reg + 20'h00001;
    end
  end

  // sender repeats the word once per frame period
  always @(posedge sys_clk) begin
    if (srst || !(enable & is_out)) begin
      tx_cyc_reg <= 20'h00000;
      tx_sh_reg  <= 19'h7ffff;
      line_o     <= 1'b1;
      line_oe    <= 1'b0;
    end else begin
      line_oe <= 1'b1;
      line_o  <= tx_sh_reg[0];
      if (tx_cyc_reg == FRAME_CYC - 1) begin
        tx_cyc_reg <= 20'h00000;
        tx_sh_reg  <= {1'b1, ^tx_word, tx_word, 1'b0};  // [R10]
      end else begin
        tx_cyc_reg <= tx_cyc_reg + 20'h00001;
        if ((tx_cyc_reg % BIT_CYC) == BIT_CYC - 1)
          tx_sh_reg <= {1'b1, tx_sh_reg[18:1]};
      end
    end
  end
endmodule // link_chan

/* File: test/link_unit_props.sv */
// checker on the link unit top ports
// assumes one clock domain and a bind onto every link_unit
`timescale 1ns/1ps
module link_unit_props #(
  parameter BIT_CYC = 8
) (
  input logic        sys_clk,
  input logic        srst,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic [2:0]  unit_sel,
  input logic [3:0]  serial_line_terminal_i,
  input logic [3:0]  serial_line_terminal_oe,
  input logic [3:0]  err_led,
  input logic        mode_led
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic        mode_w;
  logic [15:0] quiet;
  wire done = psel && penable && pready;
  wire ctrl_wr = done && pwrite && paddr == 8'h00;
  wire rd0 = done && !pwrite && paddr == 8'h40 + {1'b0, unit_sel, 4'h0};
  // quiet saturates so a long idle line never wraps to look busy
  always @(posedge sys_clk) begin
    if (ctrl_wr)
      mode_w <= pwdata[0];
    if (srst || $changed(serial_line_terminal_i[0]))
      quiet <= 16'h0;
    else if (quiet != 16'hffff)
      quiet <= quiet + 16'h1;
  end
  a_ready_late: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not on second access edge");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_idle_data: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero while idle");
  a_out_no_err: assert property (!(|(serial_line_terminal_oe & err_led)))
    else $error("error shown on output channel");
  a_err_clear: assert property ($fell(err_led[0]) |-> quiet < 20 * BIT_CYC)
    else $error("error cleared without a frame");
  a_mode_led: assert property (ctrl_wr |-> ##2 mode_led == mode_w)
    else $error("mode indicator wrong");
  a_flag_bit: assert property (rd0 && mode_led && $stable(err_led[0]) |-> prdata[15] == err_led[0])
    else $error("bit 15 differs from error state");
  c_err: cover property ($rose(err_led[0]));
  c_flag: cover property (rd0 && mode_led);
  c_slverr: cover property (pslverr);
endmodule // link_unit_props
bind link_unit link_unit_props #(.BIT_CYC(BIT_CYC)) u_props (.*);

/* File: test/remote_term.sv */
// remote input terminal model: one word per frame on its line
// assumes the frame format and period of the unit's receiver
`timescale 1ns/1ps
module remote_term #(
  parameter BIT_CYC   = 8,
  parameter FRAME_CYC = 200
) (
  input  logic        sys_clk,
  input  logic        power,
  input  logic [15:0] word,
  output logic        line
);
  logic [18:0] frm;
  logic        first;
  always begin
    line <= 1'b1; // pull-up holds an idle or unpowered line high
    wait (power);
    first = 1'b1;
    while (power) begin
      repeat (FRAME_CYC - 19 * BIT_CYC) @(posedge sys_clk);
      frm = first ? 19'h40000 : {1'b1, ^word, word, 1'b0};
      first = 1'b0;
      for (int i = 0; i < 19; i++) begin
        line <= frm[i];
        repeat (BIT_CYC) @(posedge sys_clk);
      end
    end
  end
endmodule // remote_term

/* File: test/two_wire_io_link_interface_test.sv */
// bench for link_unit: apb table, input frames, errors, output frame
// assumes remote_term on channels 0 and 1, pull-up on channels 2 and 3
`timescale 1ns/1ps
module two_wire_io_link_interface_test;
  localparam BIT_CYC = 8;
  localparam FRAME_CYC = 200;
  localparam ERR_CYC = 400;
  localparam logic [15:0] W0 = 16'hc35a;
  localparam logic [15:0] W1 = 16'h0f0f;
  typedef struct {
    bit          w;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] q;
    bit          e;
  } row_t;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        pwr0 = 1'b0;
  logic [31:0] prdata, q;
  logic        pready, pslverr, irq, mode_led, e;
  logic [63:0] point_led;
  logic [3:0]  slo, sloe, err_led;
  logic [16:0] fr;
  wire  [3:0]  sli;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          n;
  row_t rows [12] = '{
    '{1, 8'h00, 32'hc2, 0, 0}, '{0, 8'h00, 0, 32'hc2, 0},
    '{1, 8'h08, 32'h01, 0, 0}, '{0, 8'h08, 0, 32'h01, 0},
    '{0, 8'h0c, 0, 32'h6002, 0}, '{1, 8'h68, 32'h1234, 0, 0},
    '{1, 8'h6c, 32'h8001, 0, 0}, '{0, 8'h68, 0, 32'h1234, 0},
    '{1, 8'h60, 32'hffff, 0, 0}, '{0, 8'h30, 0, 0, 1},
    '{1, 8'h70, 32'h1, 0, 1}, '{0, 8'h50, 0, 0, 1}};
  always #50 sys_clk = ~sys_clk;
  assign sli[3:2] = sloe[3:2] & slo[3:2] | ~sloe[3:2];
  link_unit #(.BIT_CYC(BIT_CYC), .FRAME_CYC(FRAME_CYC), .ERR_CYC(ERR_CYC))
    u_dut (.sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .unit_sel(3'd2),
    .serial_line_terminal_i(sli), .serial_line_terminal_o(slo),
    .serial_line_terminal_oe(sloe), .point_led(point_led),
    .err_led(err_led), .mode_led(mode_led));
  remote_term #(.BIT_CYC(BIT_CYC), .FRAME_CYC(FRAME_CYC)) u_rt0 (
    .sys_clk(sys_clk), .power(pwr0), .word(W0), .line(sli[0]));
  remote_term #(.BIT_CYC(BIT_CYC), .FRAME_CYC(FRAME_CYC)) u_rt1 (
    .sys_clk(sys_clk), .power(1'b1), .word(W1), .line(sli[1]));
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(bit w, logic [7:0] a, logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1);
    chk("pready wait", 32'h2, k);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic results;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (9) @(posedge sys_clk);
    chk("reset", 32'hf, {point_led[15:0], irq, mode_led, pready, err_led,
                         slo});
    @(posedge sys_clk);
    srst <= 1'b0;
    pwr0 <= 1'b1;
    repeat (4) @(posedge sys_clk);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w)
        chk("rdata", rows[i].q, q);
      chk("slverr", rows[i].e, e);
    end
    // frame period is fixed, so two frames have surely landed by now
    repeat (500) @(posedge sys_clk);
    apb(0, 8'h60, 0);
    chk("ch0 word", W0, q);
    apb(0, 8'h64, 0);
    chk("ch1 word", W1, q);
    chk("points", {W1, W0}, point_led[31:0]);
    chk("err idle", 32'h0, err_led);
    apb(0, 8'h04, 0);
    chk("status", 32'h30, q);
    chk("irq masked", 32'h0, irq);
    apb(1, 8'h00, 32'hc3);
    apb(0, 8'h60, 0);
    chk("ch0 flag mode", W0[14:0], q);
    chk("mode led", 32'h1, mode_led);
    pwr0 <= 1'b0;
    n = 0;
    while (err_led[0] !== 1'b1 && n++ < 900) @(posedge sys_clk);
    chk("err delay", 32'h1, n >= ERR_CYC - FRAME_CYC);
    chk("err on", 32'h1, err_led[0]);
    apb(0, 8'h60, 0);
    chk("ch0 held", {1'b1, W0[14:0]}, q);
    chk("irq", 32'h1, irq);
    apb(1, 8'h04, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk("irq cleared", 32'h0, irq);
    pwr0 <= 1'b1;
    n = 0;
    while (err_led[0] !== 1'b0 && n++ < 400) @(posedge sys_clk);
    apb(0, 8'h60, 0);
    chk("ch0 zero", 32'h0, q);
    chk("err off", 32'h0, err_led[0]);
    // sync on a long idle stretch so a data zero is not taken for start
    n = 0;
    for (int k = 0; k < 24 && n < 600; n++) begin
      @(posedge sys_clk);
      k = slo[2] ? k + 1 : 0;
    end
    while (slo[2] !== 1'b0 && n++ < 900) @(posedge sys_clk);
    repeat (BIT_CYC + BIT_CYC / 2 - 1) @(posedge sys_clk);
    for (int i = 0; i < 17; i++) begin
      fr[i] = slo[2];
      repeat (BIT_CYC) @(posedge sys_clk);
    end
    chk("ch2 frame", {^16'h1234, 16'h1234}, fr);
    chk("ch2 points", 32'h1234, point_led[47:32]);
    chk("oe", 32'hc, sloe);
    apb(1, 8'h00, 32'h00);
    apb(0, 8'h68, 0);
    chk("two ch", 32'h1, e);
    apb(0, 8'h64, 0);
    chk("two ch1", W1, q);
    results;
  end
  initial begin
    repeat (8000) @(posedge sys_clk);
    n_errors++;
    results;
  end
endmodule // two_wire_io_link_interface_test
